/* File: common/aas_defines.vh */
/*
  Constants for the accumulator datapath subset: register byte offsets,
  status bit positions, instruction word fields, opcodes and reset values.
  Assumes a 32-bit AHB-Lite slave decoding 12 address bits.
*/
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH

// register byte offsets
`define AAS_OFS_ACCUM      12'h000
`define AAS_OFS_STATUS     12'h004
`define AAS_OFS_INSTR      12'h008
`define AAS_OFS_DIR_A      12'h00C
`define AAS_OFS_DIR_B      12'h010
`define AAS_OFS_DIR_C      12'h014
`define AAS_OFS_WATCHDOG   12'h018
`define AAS_OFS_CTRL       12'h01C
// file registers: base + 4 * file address, 128 entries
`define AAS_OFS_FILE_BASE  12'h200
`define AAS_FILE_SEL_HI    11
`define AAS_FILE_SEL_LO    9
`define AAS_FILE_SEL_VAL   3'h1

// status bit positions
`define AAS_ST_CARRY       0
`define AAS_ST_HALF_CARRY  1
`define AAS_ST_ZERO        2
`define AAS_ST_POWERDOWN   3
`define AAS_ST_TIMEOUT     4
`define AAS_ST_SLEEPING    5

// instruction word fields
`define AAS_IN_OPERAND_HI  7
`define AAS_IN_OPERAND_LO  0
`define AAS_IN_OPCODE_HI   11
`define AAS_IN_OPCODE_LO   8
`define AAS_IN_DEST        12
`define AAS_CTRL_WAKE      0

// opcodes
`define AAS_OP_LITERAL_SUBTRACT   4'h0
`define AAS_OP_REGISTER_SUBTRACT  4'h1
`define AAS_OP_SUBTRACT_BORROW    4'h2
`define AAS_OP_NIBBLE_SWAP        4'h3
`define AAS_OP_LITERAL_XOR        4'h4
`define AAS_OP_REGISTER_XOR       4'h5
`define AAS_OP_PORT_DIRECTION     4'h6
`define AAS_OP_POWERDOWN_ENTRY    4'h7

// port direction operands
`define AAS_DIR_SEL_A      8'h05
`define AAS_DIR_SEL_B      8'h06
`define AAS_DIR_SEL_C      8'h07

// reset values
`define AAS_RST_BYTE       8'h00
`define AAS_RST_DIR        8'hFF
`define AAS_RST_WORD       32'h0000_0000
`define AAS_WATCHDOG_CLEAR 8'h00

`endif

/* File: rtl/aas_alu_subset.v */
/*
  Execution datapath for a subset of an 8-bit accumulator core: subtracts,
  nibble swap, exclusive-ORs, port-direction loads and power-down entry,
  plus a small watchdog and 128 file registers, all reached over AHB-Lite.
  Assumes one 200 MHz clock, a single AHB-Lite master, word transfers only.
*/
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "aas_defines.vh"

// Notes on behaviour
// - literal-subtract puts literal minus accumulator into the accumulator and updates C, DC, Z.
// - for literal-subtract C is 0 when the accumulator exceeds the literal, DC likewise on nibbles.
// - power-down entry zeroes the watchdog counter and prescaler, sets timeout and clears powerdown.
// - after power-down entry the core sleeps, ignoring instruction writes with its watchdog frozen, until woken.
// - register-subtract puts file minus accumulator into the accumulator or the file by dest bit.
// - for register-subtract C and DC compare accumulator and file as above, and Z is updated.
// - subtract-with-borrow takes file minus accumulator minus inverted carry, updating C, DC, Z.
// - nibble-swap exchanges the file register's nibbles into the destination, flags untouched.
// - literal exclusive-OR puts accumulator xor literal in the accumulator, touching only Z.
// - register exclusive-OR puts accumulator xor file into the destination, touching only Z.
// - port-direction load copies the accumulator to port A, B or C direction for operand 5, 6, 7.
module aas_alu_subset (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output wire        sleep_o,
  output wire [7:0]  port_a_direction_o,
  output wire [7:0]  port_b_direction_o,
  output wire [7:0]  port_c_direction_o,
  output wire [7:0]  watchdog_counter_o
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // {carry, half_carry, result} of a - b - (1 - cin), two's complement
  function [9:0] sub_flags;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] full;
    reg   [4:0] low;
    begin
      full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      sub_flags = {full[8], low[4], full[7:0]};
    end
  endfunction

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  function is_file_addr;
    input [11:0] a;
    begin
      is_file_addr = (a[`AAS_FILE_SEL_HI:`AAS_FILE_SEL_LO] == `AAS_FILE_SEL_VAL);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [31:0] hrdata_reg;
  reg        hreadyout_reg;
  reg        hresp_reg;
  reg        wr_pend_reg;
  reg [11:0] wr_addr_reg;

  reg [7:0]  accum_reg;
  reg [7:0]  accum_next;
  reg        carry_reg;
  reg        carry_next;
  reg        half_carry_reg;
  reg        half_carry_next;
  reg        zero_reg;
  reg        zero_next;
  reg        powerdown_status_flag_reg;
  reg        powerdown_status_flag_next;
  reg        timeout_status_flag_reg;
  reg        timeout_status_flag_next;
  reg        sleep_reg;
  reg        sleep_next;
  reg [7:0]  dir_a_reg;
  reg [7:0]  dir_a_next;
  reg [7:0]  dir_b_reg;
  reg [7:0]  dir_b_next;
  reg [7:0]  dir_c_reg;
  reg [7:0]  dir_c_next;
  reg [7:0]  watchdog_counter_reg;
  reg [7:0]  watchdog_counter_next;
  reg [7:0]  prescaler_reg;
  reg [7:0]  prescaler_next;

  reg [7:0]  file_mem [0:127];
  reg        file_we;
  reg [6:0]  file_wa;
  reg [7:0]  file_wd;

  wire [7:0] status_byte;
  wire       addr_taken;
  wire       wr_commit;
  wire [3:0] op;
  wire [7:0] operand;
  wire       dest_file;
  wire [6:0] file_addr;
  wire [7:0] file_val;
  wire [9:0] sub_lit;
  wire [9:0] sub_file;
  wire [9:0] sub_borrow;
  wire [7:0] swapped;
  wire [7:0] xor_lit;
  wire [7:0] xor_file;

  assign status_byte = {2'b00, sleep_reg, timeout_status_flag_reg,
                        powerdown_status_flag_reg, zero_reg, half_carry_reg, carry_reg};

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: reads answer without wait; writes insert one wait state

  assign addr_taken = hsel_i & htrans_i[1] & hready_i;
  assign wr_commit  = wr_pend_reg;

  function [31:0] read_mux;
    input [11:0] a;
    begin
      read_mux = `AAS_RST_WORD;
      if (is_file_addr(a))
        read_mux = {24'h00_0000, file_mem[a[8:2]]};
      else
      begin
        case (a)
          `AAS_OFS_ACCUM:    read_mux = {24'h00_0000, accum_reg};
          `AAS_OFS_STATUS:   read_mux = {24'h00_0000, status_byte};
          `AAS_OFS_DIR_A:    read_mux = {24'h00_0000, dir_a_reg};
          `AAS_OFS_DIR_B:    read_mux = {24'h00_0000, dir_b_reg};
          `AAS_OFS_DIR_C:    read_mux = {24'h00_0000, dir_c_reg};
          `AAS_OFS_WATCHDOG: read_mux = {24'h00_0000, watchdog_counter_reg};
          default:           read_mux = `AAS_RST_WORD;
        endcase
      end
    end
  endfunction

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hrdata_reg    <= `AAS_RST_WORD;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 12'h000;
    end
    else
    begin
      hresp_reg <= 1'b0;
      if (wr_pend_reg)
      begin
        wr_pend_reg   <= 1'b0;
        hreadyout_reg <= 1'b1;
      end
      else if (addr_taken && hwrite_i)
      begin
        wr_pend_reg   <= 1'b1;
        wr_addr_reg   <= {haddr_i[11:2], 2'b00};
        hreadyout_reg <= 1'b0;
      end
      else if (addr_taken)
        hrdata_reg <= read_mux({haddr_i[11:2], 2'b00});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  assign op        = hwdata_i[`AAS_IN_OPCODE_HI:`AAS_IN_OPCODE_LO];
  assign operand   = hwdata_i[`AAS_IN_OPERAND_HI:`AAS_IN_OPERAND_LO];
  assign dest_file = hwdata_i[`AAS_IN_DEST];
  assign file_addr = operand[6:0];
  assign file_val  = file_mem[file_addr];

  assign sub_lit    = sub_flags(operand, accum_reg, 1'b1);
  assign sub_file   = sub_flags(file_val, accum_reg, 1'b1);
  assign sub_borrow = sub_flags(file_val, accum_reg, carry_reg);
  assign swapped    = {file_val[3:0], file_val[7:4]};
  assign xor_lit    = accum_reg ^ operand;
  assign xor_file   = accum_reg ^ file_val;

  always @*
  begin
    accum_next                 = accum_reg;
    carry_next                 = carry_reg;
    half_carry_next            = half_carry_reg;
    zero_next                  = zero_reg;
    powerdown_status_flag_next = powerdown_status_flag_reg;
    timeout_status_flag_next   = timeout_status_flag_reg;
    sleep_next                 = sleep_reg;
    dir_a_next                 = dir_a_reg;
    dir_b_next                 = dir_b_reg;
    dir_c_next                 = dir_c_reg;
    file_we                    = 1'b0;
    file_wa                    = wr_addr_reg[8:2];
    file_wd                    = hwdata_i[7:0];
    // watchdog runs only while the core is awake
    prescaler_next             = sleep_reg ? prescaler_reg : prescaler_reg + 8'h01;
    watchdog_counter_next      = watchdog_counter_reg;
    if (!sleep_reg && prescaler_reg == 8'hFF)
      watchdog_counter_next = watchdog_counter_reg + 8'h01;

    if (wr_commit)
    begin
      if (is_file_addr(wr_addr_reg))
        file_we = 1'b1;
      else
      begin
        case (wr_addr_reg)
          `AAS_OFS_ACCUM:  accum_next = hwdata_i[7:0];
          `AAS_OFS_STATUS:
          begin
            carry_next                 = hwdata_i[`AAS_ST_CARRY];
            half_carry_next            = hwdata_i[`AAS_ST_HALF_CARRY];
            zero_next                  = hwdata_i[`AAS_ST_ZERO];
            powerdown_status_flag_next = hwdata_i[`AAS_ST_POWERDOWN];
            timeout_status_flag_next   = hwdata_i[`AAS_ST_TIMEOUT];
          end
          `AAS_OFS_DIR_A:  dir_a_next = hwdata_i[7:0];
          `AAS_OFS_DIR_B:  dir_b_next = hwdata_i[7:0];
          `AAS_OFS_DIR_C:  dir_c_next = hwdata_i[7:0];
          `AAS_OFS_CTRL:
            if (hwdata_i[`AAS_CTRL_WAKE])
              sleep_next = 1'b0;
          `AAS_OFS_INSTR:
            // a sleeping core executes nothing
            if (!sleep_reg)
            begin
              file_wa = file_addr;
              case (op)
                `AAS_OP_LITERAL_SUBTRACT:
                begin
                  accum_next      = sub_lit[7:0];
                  carry_next      = sub_lit[9];
                  half_carry_next = sub_lit[8];
                  zero_next       = is_zero(sub_lit[7:0]);
                end
                `AAS_OP_REGISTER_SUBTRACT:
                begin
                  if (dest_file)
                    file_we = 1'b1;
                  else
                    accum_next = sub_file[7:0];
                  file_wd         = sub_file[7:0];
                  carry_next      = sub_file[9];
                  half_carry_next = sub_file[8];
                  zero_next       = is_zero(sub_file[7:0]);
                end
                `AAS_OP_SUBTRACT_BORROW:
                begin
                  if (dest_file)
                    file_we = 1'b1;
                  else
                    accum_next = sub_borrow[7:0];
                  file_wd         = sub_borrow[7:0];
                  carry_next      = sub_borrow[9];
                  half_carry_next = sub_borrow[8];
                  zero_next       = is_zero(sub_borrow[7:0]);
                end
                `AAS_OP_NIBBLE_SWAP:
                begin
                  if (dest_file)
                    file_we = 1'b1;
                  else
                    accum_next = swapped;
                  file_wd = swapped;
                end
                `AAS_OP_LITERAL_XOR:
                begin
                  accum_next = xor_lit;
                  zero_next  = is_zero(xor_lit);
                end
                `AAS_OP_REGISTER_XOR:
                begin
                  if (dest_file)
                    file_we = 1'b1;
                  else
                    accum_next = xor_file;
                  file_wd   = xor_file;
                  zero_next = is_zero(xor_file);
                end
                `AAS_OP_PORT_DIRECTION:
                begin
                  case (operand)
                    `AAS_DIR_SEL_A: dir_a_next = accum_reg;
                    `AAS_DIR_SEL_B: dir_b_next = accum_reg;
                    `AAS_DIR_SEL_C: dir_c_next = accum_reg;
                    default:        dir_a_next = dir_a_reg;
                  endcase
                end
                `AAS_OP_POWERDOWN_ENTRY:
                begin
                  watchdog_counter_next      = `AAS_WATCHDOG_CLEAR;
                  prescaler_next             = `AAS_WATCHDOG_CLEAR;
                  timeout_status_flag_next   = 1'b1;
                  powerdown_status_flag_next = 1'b0;
                  sleep_next                 = 1'b1;
                end
                default:
                  accum_next = accum_reg;
              endcase
            end
          default:
            accum_next = accum_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      accum_reg                 <= `AAS_RST_BYTE;
      carry_reg                 <= 1'b0;
      half_carry_reg            <= 1'b0;
      zero_reg                  <= 1'b0;
      powerdown_status_flag_reg <= 1'b1;
      timeout_status_flag_reg   <= 1'b1;
      sleep_reg                 <= 1'b0;
      dir_a_reg                 <= `AAS_RST_DIR;
      dir_b_reg                 <= `AAS_RST_DIR;
      dir_c_reg                 <= `AAS_RST_DIR;
      watchdog_counter_reg      <= `AAS_RST_BYTE;
      prescaler_reg             <= `AAS_RST_BYTE;
    end
    else
    begin
      accum_reg                 <= accum_next;
      carry_reg                 <= carry_next;
      half_carry_reg            <= half_carry_next;
      zero_reg                  <= zero_next;
      powerdown_status_flag_reg <= powerdown_status_flag_next;
      timeout_status_flag_reg   <= timeout_status_flag_next;
      sleep_reg                 <= sleep_next;
      dir_a_reg                 <= dir_a_next;
      dir_b_reg                 <= dir_b_next;
      dir_c_reg                 <= dir_c_next;
      watchdog_counter_reg      <= watchdog_counter_next;
      prescaler_reg             <= prescaler_next;
    end
  end

  // file storage carries no reset
  always @(posedge clk_i)
  begin
    if (file_we)
      file_mem[file_wa] <= file_wd;
  end

  assign hrdata_o           = hrdata_reg;
  assign hreadyout_o        = hreadyout_reg;
  assign hresp_o            = hresp_reg;
  assign sleep_o            = sleep_reg;
  assign port_a_direction_o = dir_a_reg;
  assign port_b_direction_o = dir_b_reg;
  assign port_c_direction_o = dir_c_reg;
  assign watchdog_counter_o = watchdog_counter_reg;

endmodule

/* File: tb/aas_alu_subset_props.sv */
/*
  Checker on the ports of aas_alu_subset, bound at the foot.
  Assumes one clock, hready tied to hreadyout, word transfers only.
*/
`timescale 1ns/1ps
`include "aas_defines.vh"
module aas_alu_subset_props (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [2:0]  hsize_i,
  input wire [31:0] hwdata_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        sleep_o,
  input wire [7:0]  port_a_direction_o,
  input wire [7:0]  port_b_direction_o,
  input wire [7:0]  port_c_direction_o,
  input wire [7:0]  watchdog_counter_o
);
  reg        dph;
  reg        dwr;
  reg [11:0] dadr;
  wire       tk   = hsel_i & htrans_i[1] & hready_i;
  wire       cm   = dph & dwr & ~hreadyout_o;
  wire       ic   = cm & (dadr == `AAS_OFS_INSTR) & ~sleep_o;
  wire [3:0] op   = hwdata_i[11:8];
  wire       pde  = ic & (op == `AAS_OP_POWERDOWN_ENTRY);
  wire       pl   = ic & (op == `AAS_OP_PORT_DIRECTION);
  wire       ld_a = (pl & (hwdata_i[7:0] == `AAS_DIR_SEL_A)) | (cm & (dadr == `AAS_OFS_DIR_A));
  wire       ld_b = (pl & (hwdata_i[7:0] == `AAS_DIR_SEL_B)) | (cm & (dadr == `AAS_OFS_DIR_B));
  wire       ld_c = (pl & (hwdata_i[7:0] == `AAS_DIR_SEL_C)) | (cm & (dadr == `AAS_OFS_DIR_C));
  wire       wake = cm & (dadr == `AAS_OFS_CTRL) & hwdata_i[`AAS_CTRL_WAKE];
  // tracks the data phase that follows each accepted address phase
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dph  <= 1'b0;
      dwr  <= 1'b0;
      dadr <= 12'h000;
    end
    else if (hready_i)
    begin
      dph  <= tk;
      dwr  <= hwrite_i;
      dadr <= haddr_i[11:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_resp; !hresp_o; endproperty
  property p_rd_fast; tk && !hwrite_i |=> hreadyout_o; endproperty
  property p_wr_wait; tk && hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
  property p_pd_entry; pde |=> watchdog_counter_o == `AAS_WATCHDOG_CLEAR && sleep_o; endproperty
  property p_freeze; sleep_o |=> $stable(watchdog_counter_o); endproperty
  property p_sleep_hold; sleep_o && !wake |=> sleep_o; endproperty
  property p_wd_step;
    !sleep_o && !pde |=> watchdog_counter_o == $past(watchdog_counter_o)
      || watchdog_counter_o == $past(watchdog_counter_o) + 8'h01;
  endproperty
  property p_port_a; $changed(port_a_direction_o) |-> $past(ld_a); endproperty
  property p_port_b; $changed(port_b_direction_o) |-> $past(ld_b); endproperty
  property p_port_c; $changed(port_c_direction_o) |-> $past(ld_c); endproperty
  a_resp: assert property (p_resp) else $error("response not OKAY");
  a_rd_fast: assert property (p_rd_fast) else $error("read data phase stalled");
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entry wrong");
  a_freeze: assert property (p_freeze) else $error("watchdog moved asleep");
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");
  a_wd_step: assert property (p_wd_step) else $error("watchdog jumped");
  a_port_a: assert property (p_port_a) else $error("port A direction stray");
  a_port_b: assert property (p_port_b) else $error("port B direction stray");
  a_port_c: assert property (p_port_c) else $error("port C direction stray");
  c_pd: cover property (pde);
  c_pl: cover property (pl);
  c_borrow: cover property (ic && op == `AAS_OP_SUBTRACT_BORROW);
endmodule
bind aas_alu_subset aas_alu_subset_props chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sleep_o(sleep_o),
  .port_a_direction_o(port_a_direction_o), .port_b_direction_o(port_b_direction_o),
  .port_c_direction_o(port_c_direction_o), .watchdog_counter_o(watchdog_counter_o));

/* File: tb/aas_alu_subset_test.sv */
/*
  Self-checking bench for aas_alu_subset: reference model, queued read checks.
  Assumes the bus model in aas_bus_model and the defines header on the path.
*/
`timescale 1ns/1ps
`include "aas_defines.vh"
module aas_alu_subset_test;
  reg          clk_i    = 1'b0;
  reg          resetn_i = 1'b0;
  wire [1:0]   htrans;
  wire [31:0]  haddr, hwdata, hrdata, rd_data;
  wire         hwrite, hready, hresp, sleep, rd_done;
  wire [2:0]   hsize;
  wire [7:0]   dir_a, dir_b, dir_c, wdog;
  integer      seed     = 22042;
  integer      n_errors = 0;
  integer      checks   = 0;
  integer      cycles   = 0;
  integer      i;
  logic [31:0] exp_q[$];
  logic [7:0]  acc, ma, mb, mc, k, v, fv, fm[0:127];
  logic        c, dc, z, pd, to, sl, d;
  logic [2:0]  rf;
  logic [3:0]  op;
  aas_alu_subset dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sleep_o(sleep), .port_a_direction_o(dir_a), .port_b_direction_o(dir_b),
    .port_c_direction_o(dir_c), .watchdog_counter_o(wdog));
  aas_bus_model bus_u (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .htrans_o(htrans),
    .haddr_o(haddr), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
    .done_o(rd_done), .data_o(rd_data));
  initial forever #2.5 clk_i = ~clk_i;
  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t timeout", $time);
      finish_test;
    end
  end
  task cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_pin(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t sleep %b expected %b", $time, got, exp);
    end
  endtask
  always @(posedge clk_i) if (rd_done === 1'b1) cmp_rd(rd_data, exp_q.pop_front());
  task wr(input logic [11:0] a, input logic [31:0] dv);
    bus_u.xfer(1'b1, a, dv);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus_u.xfer(1'b0, a, 32'h0000_0000);
  endtask
  function logic [7:0] st();
    st = {2'b00, sl, to, pd, z, dc, c};
  endfunction
  task sub(input logic [7:0] a, input logic ci, output logic [7:0] r);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~acc} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, ci};
    r = s[7:0];
    c = s[8];
    dc = h[4];
  endtask
  task ex(input logic [3:0] o, input logic [7:0] p, input logic dd);
    logic [7:0] f, r;
    f = fm[p[6:0]];
    r = acc;
    if (!sl && o < 4'h6)
    begin
      case (o)
        4'h0: sub(p, 1'b1, r);
        4'h1: sub(f, 1'b1, r);
        4'h2: sub(f, c, r);
        4'h3: r = {f[3:0], f[7:4]};
        4'h4: r = acc ^ p;
        default: r = acc ^ f;
      endcase
      if (o != 4'h3) z = (r == 8'h00);
      if (dd && o != 4'h0 && o != 4'h4) fm[p[6:0]] = r;
      else acc = r;
    end
    else if (!sl && o == 4'h6)
    begin
      if (p == 8'h05) ma = acc;
      if (p == 8'h06) mb = acc;
      if (p == 8'h07) mc = acc;
    end
    else if (!sl && o == 4'h7)
    begin
      to = 1'b1;
      pd = 1'b0;
      sl = 1'b1;
    end
    wr(`AAS_OFS_INSTR, {19'h0_0000, dd, o, p});
  endtask
  task reset_model;
    {acc, c, dc, z, pd, to, sl} = {8'h00, 6'b000110};
    {ma, mb, mc} = {8'hFF, 8'hFF, 8'hFF};
  endtask
  initial
  begin
    reset_model;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`AAS_OFS_STATUS, st());
    rd(`AAS_OFS_DIR_C, mc);
    wr(12'h100, 32'h0000_00A5);
    rd(12'h100, 8'h00);
    rd(`AAS_OFS_INSTR, 8'h00);
    for (i = 0; i < 60; i = i + 1)
    begin
      v = $random(seed);
      k = $random(seed);
      fv = $random(seed);
      rf = $random(seed);
      d = $random(seed);
      op = {$random(seed)} % 6;
      if (i < 12)
      begin
        op = i % 6;
        fv = v;
        k = (i < 6) ? v : k;
      end
      wr(`AAS_OFS_ACCUM, {24'h00_0000, v});
      acc = v;
      wr(`AAS_OFS_FILE_BASE + {3'b000, k[6:0], 2'b00}, {24'h00_0000, fv});
      fm[k[6:0]] = fv;
      wr(`AAS_OFS_STATUS, {27'h000_0000, to, pd, rf});
      {z, dc, c} = rf;
      ex(op, k, d);
      rd(`AAS_OFS_ACCUM, acc);
      rd(`AAS_OFS_STATUS, st());
      rd(`AAS_OFS_FILE_BASE + {3'b000, k[6:0], 2'b00}, fm[k[6:0]]);
    end
    for (i = 4; i < 9; i = i + 1)
    begin
      v = $random(seed);
      wr(`AAS_OFS_ACCUM, {24'h00_0000, v});
      acc = v;
      ex(4'h6, i[7:0], 1'b0);
      rd(`AAS_OFS_DIR_A, ma);
      rd(`AAS_OFS_DIR_B, mb);
      rd(`AAS_OFS_DIR_C, mc);
      rd(`AAS_OFS_STATUS, st());
    end
    ex(4'h9, 8'h3C, 1'b0);
    rd(`AAS_OFS_ACCUM, acc);
    ex(4'h7, 8'h00, 1'b0);
    #1 cmp_pin(sleep, 1'b1);
    rd(`AAS_OFS_STATUS, st());
    rd(`AAS_OFS_WATCHDOG, 8'h00);
    repeat (300) @(posedge clk_i);
    ex(4'h4, 8'hFF, 1'b0);
    rd(`AAS_OFS_WATCHDOG, 8'h00);
    rd(`AAS_OFS_ACCUM, acc);
    wr(`AAS_OFS_CTRL, 32'h0000_0001);
    sl = 1'b0;
    #1 cmp_pin(sleep, 1'b0);
    rd(`AAS_OFS_STATUS, st());
    repeat (600) @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    reset_model;
    rd(`AAS_OFS_STATUS, st());
    rd(`AAS_OFS_DIR_A, ma);
    repeat (2) @(posedge clk_i);
    finish_test;
  end
endmodule

/* File: tb/aas_bus_model.sv */
/*
  Bus master standing for the core's sequencer: issues single word AHB-Lite transfers.
  Assumes hready is the slave's hreadyout and hsel is held high by the bench.
*/
`timescale 1ns/1ps
module aas_bus_model (
  input  wire         clk_i,
  input  wire         hready_i,
  input  wire  [31:0] hrdata_i,
  output logic [1:0]  htrans_o,
  output logic [31:0] haddr_o,
  output logic        hwrite_o,
  output logic [2:0]  hsize_o,
  output logic [31:0] hwdata_o,
  output logic        done_o,
  output logic [31:0] data_o
);
  initial
  begin
    htrans_o = 2'h0;
    haddr_o  = 32'h0000_0000;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0000_0000;
    done_o   = 1'b0;
    data_o   = 32'h0000_0000;
  end
  // unqualified lines toggle so a stale value is never mistaken for a live one
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dv);
    @(posedge clk_i);
    htrans_o <= 2'h2;
    haddr_o  <= {20'h0_0000, a};
    hwrite_o <= w;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'h0;
    haddr_o  <= ~haddr_o;
    hwdata_o <= w ? dv : ~hwdata_o;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    data_o <= hrdata_i;
    done_o <= ~w;
    @(posedge clk_i);
    done_o <= 1'b0;
  endtask
endmodule
